// >>> hw/fprta_defines.svh
`ifndef FPRTA_DEFINES_SVH
`define FPRTA_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FPRTA_OFS_CTRL 8'h00
`define FPRTA_OFS_WAIT 8'h04
`define FPRTA_OFS_HOLD 8'h08
`define FPRTA_OFS_CNT 8'h0C

// ----------------------------------------
// Control field positions and codes
// ----------------------------------------
`define FPRTA_CTRL_STAT_EN 0
`define FPRTA_CTRL_SCHED 5
`define FPRTA_CTRL_MODE_LO 13
`define FPRTA_CTRL_MODE_HI 14
`define FPRTA_MODE_EXPL 2'h0
`define FPRTA_MODE_HB 2'h1
`define FPRTA_MODE_ONE 2'h2
`define FPRTA_MODE_RST 2'h0
`define FPRTA_MSG_CANCEL 2'h3

// ----------------------------------------
// Timing counts and reset values
// ----------------------------------------
`define FPRTA_WAIT_RST 4'h6
`define FPRTA_EOP_GAP 3'h4
`define FPRTA_RESP_OK 2'h0
`define FPRTA_RESP_ERR 2'h2

`endif

// >>> hw/fprta_pkg.sv
package fprta_pkg;

    typedef struct packed {
        logic [4:0] thread_id;
        logic [4:0] port;
        logic [1:0] msg;
        logic [3:0] element_first;
        logic [3:0] element_second;
        logic fast_sel;
    } fprta_req_t;

    typedef struct packed {
        logic [1:0] msg;
        logic [4:0] port_thd;
        logic [3:0] sop_seq;
        logic fail;
        logic err;
        logic [3:0] element_second;
        logic [3:0] element_first;
        logic seq_sel;
        logic eop;
        logic sop;
        logic [3:0] seg_seq;
    } fprta_comp_t;

    typedef struct packed {
        logic valid;
        logic sop;
        logic eop;
        logic fail;
        logic seg_end;
    } fprta_bus_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_GAP,
        ST_RECV,
        ST_STAT,
        ST_DRAIN
    } fprta_state_t;

endpackage

// >>> hw/fprta_port_ctx.sv
`include "fprta_defines.svh"

module fprta_port_ctx
    import fprta_pkg::*;
#(
    parameter int WAIT_W = 4
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic [WAIT_W-1:0] wait_len,
    input wire logic done,
    input wire logic adv,
    input wire logic sop,
    // State
    output logic wait_busy,
    output logic [3:0] sop_seq,
    output logic [3:0] seg_seq
);

    logic [WAIT_W-1:0] wait_q;
    logic [3:0] sop_q;
    logic [3:0] seg_q;

    // ----------------------------------------
    // Ready sample wait
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            wait_q <= '0;
        else if (done)
            wait_q <= wait_len;
        else if (wait_q != '0)
            wait_q <= wait_q - WAIT_W'(1);
    end

    // ----------------------------------------
    // Packet start and segment counters
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sop_q <= 4'h0;
            seg_q <= 4'h0;
        end
        else if (adv && sop)
        begin
            sop_q <= sop_q + 4'h1;
            seg_q <= sop_q;
        end
        else if (adv)
            seg_q <= seg_q + 4'h1;
    end

    assign wait_busy = (wait_q != '0);
    assign sop_seq = sop_q;
    assign seg_seq = seg_q;

    wait_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (done && wait_len == WAIT_W'(3)) |=> wait_busy [*3] ##1
            (!wait_busy || $past(done)))
        else $error("ready wait length not honoured");

    seq_load_a: assert property (@(posedge clk) disable iff (!reset_n)
        (adv && sop) |=> (seg_seq == $past(sop_seq)) &&
            (sop_seq == $past(sop_seq) + 4'h1))
        else $error("segment counter did not load start counter");

endmodule // fprta_port_ctx

// >>> hw/fprta_top.sv
// Overview of operation
// - Two-bit mode: 00 explicit, 01 header/body, 10 single thread.
// - Single mode, start seen: signal requested thread, store as header.
// - Single mode, no start: signal header, report unused thread.
// - Header/body: start stores header, next request stores body thread.
// - Header/body later segments: signal body, report unused thread unless failed.
// - Explicit: always signal requested thread, supply segment sequence.
// - Scheduler signalling: completion must be read twice before removal.
// - Back-to-back same port: 4-cycle gap; read status after end.
// - Per-port 4-bit wait after completion before sampling ready.
// - Complete after end cycle, at status request, or after failure.
// - Each per-port wait count resets to 6.
// - Cancel writes message 3, requested port, flags zero, elements.
// - Cancel signals requested thread, scheduler if enabled, counts.
// - Failure copies message and elements, fail 1, select bit.
// - Failure port/thread field: port, or thread in single mode with no start seen.
// - Failure thread: requested, header/body, or header in single.
// - Failure reports start sequence, bumps it on start, counts.
// - Sample port ready before processing; not ready cancels request.
// - Start and segment counters; segment loads start on start.
`include "fprta_defines.svh"

module fprta_top
    import fprta_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Receive requests
    input wire logic req_valid,
    input wire fprta_req_t req_data,
    output logic req_ready,
    // Receive bus
    input wire logic ready_in_port_a,
    input wire logic ready_in_port_b,
    input wire fprta_bus_t rx_bus,
    output logic status_req,
    // Completion status
    output logic comp_valid,
    output fprta_comp_t comp_data,
    input wire logic comp_read,
    // Thread signals
    output logic thread_sig_valid,
    output logic [4:0] thread_sig_id,
    output logic sched_sig
);

    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = new_v[i*8 +: 8];
        return r;
    endfunction

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] mode_q;
    logic sig_sched_q, stat_en_q;
    logic [3:0] wait_a_q, wait_b_q;
    logic [4:0] header_q, body_q;
    logic body_valid_q;
    logic [7:0] coll_q;
    logic [3:0] sop_seq_w [2];
    logic [3:0] seg_seq_w [2];
    logic [1:0] busy_w;

    wire [31:0] ctrl_word = {17'h0, mode_q, 7'h0, sig_sched_q, 4'h0,
        stat_en_q};
    wire [31:0] wait_word = {24'h0, wait_b_q, wait_a_q};
    wire [31:0] hold_word = {15'h0, body_valid_q, 3'h0, body_q, 3'h0,
        header_q};
    wire [31:0] cnt_word = {16'h0, sop_seq_w[1], sop_seq_w[0], coll_q};
    wire do_write = !awready_q && !wready_q && !bvalid_q;
    wire wr_ctrl = do_write && awaddr_q == `FPRTA_OFS_CTRL;
    wire wr_wait = do_write && awaddr_q == `FPRTA_OFS_WAIT;
    wire wr_ok = awaddr_q == `FPRTA_OFS_CTRL || awaddr_q == `FPRTA_OFS_WAIT;
    wire [31:0] ctrl_new = merge_be(ctrl_word, wdata_q, wstrb_q);
    wire [31:0] wait_new = merge_be(wait_word, wdata_q, wstrb_q);
    wire rd_hit = s_axi_araddr == `FPRTA_OFS_CTRL ||
        s_axi_araddr == `FPRTA_OFS_WAIT ||
        s_axi_araddr == `FPRTA_OFS_HOLD || s_axi_araddr == `FPRTA_OFS_CNT;
    wire [31:0] rd_mux =
        s_axi_araddr == `FPRTA_OFS_CTRL ? ctrl_word :
        s_axi_araddr == `FPRTA_OFS_WAIT ? wait_word :
        s_axi_araddr == `FPRTA_OFS_HOLD ? hold_word :
        s_axi_araddr == `FPRTA_OFS_CNT ? cnt_word : 32'h0;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `FPRTA_RESP_OK;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && awready_q)
            begin
                awaddr_q <= s_axi_awaddr;
                awready_q <= 1'b0;
            end
            if (s_axi_wvalid && wready_q)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                wready_q <= 1'b0;
            end
            if (do_write)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? `FPRTA_RESP_OK : `FPRTA_RESP_ERR;
            end
            if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= `FPRTA_RESP_OK;
        end
        else if (s_axi_arvalid && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? `FPRTA_RESP_OK : `FPRTA_RESP_ERR;
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_q <= `FPRTA_MODE_RST;
            sig_sched_q <= 1'b0;
            stat_en_q <= 1'b0;
            wait_a_q <= `FPRTA_WAIT_RST;
            wait_b_q <= `FPRTA_WAIT_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                mode_q <= ctrl_new[`FPRTA_CTRL_MODE_HI:`FPRTA_CTRL_MODE_LO];
                sig_sched_q <= ctrl_new[`FPRTA_CTRL_SCHED];
                stat_en_q <= ctrl_new[`FPRTA_CTRL_STAT_EN];
            end
            if (wr_wait)
            begin
                wait_a_q <= wait_new[3:0];
                wait_b_q <= wait_new[7:4];
            end
        end
    end

    // ----------------------------------------
    // Request sequencing
    // ----------------------------------------
    fprta_state_t state_q, state_d;
    fprta_req_t req_q;
    fprta_comp_t comp_q;
    logic sop_seen_q, eop_seen_q, last_sel_q, last_valid_q;
    logic [2:0] gap_q;
    logic [1:0] reads_left_q;
    logic comp_valid_q;
    logic req_ready_q, status_req_q, thr_valid_q, sched_q;
    logic [4:0] thr_id_q;

    wire sel = req_q.fast_sel;
    wire ready_sel = sel ? ready_in_port_b : ready_in_port_a;
    wire b2b = last_valid_q && last_sel_q == sel && gap_q != 3'h0;
    wire gap_go = !busy_w[sel] && !b2b;
    wire bus_cyc = state_q == ST_RECV && rx_bus.valid;
    wire cancel_ev = state_q == ST_GAP && gap_go && !ready_sel;
    wire fail_ev = bus_cyc && rx_bus.fail;
    wire stat_go = bus_cyc && !rx_bus.fail && rx_bus.eop && stat_en_q;
    wire ok_ev = state_q == ST_STAT || (bus_cyc && !rx_bus.fail &&
        (rx_bus.eop || rx_bus.seg_end) && !stat_go);
    wire done_ev = cancel_ev || fail_ev || ok_ev;
    wire sop_cur = sop_seen_q || (bus_cyc && rx_bus.sop);
    wire eop_cur = eop_seen_q || (bus_cyc && rx_bus.eop);
    wire m_one = mode_q == `FPRTA_MODE_ONE;
    wire m_hb = mode_q == `FPRTA_MODE_HB;
    wire subst = m_one ? !sop_cur : (m_hb && !sop_cur && body_valid_q);
    wire [4:0] thr_pick = m_one ? (sop_cur ? req_q.thread_id : header_q) :
        subst ? body_q : req_q.thread_id;
    wire [4:0] pt_ok = subst ? req_q.thread_id : req_q.port;
    wire [4:0] pt_fail = (m_one && !sop_cur) ? req_q.thread_id :
        req_q.port;
    wire [3:0] seg_rep = sop_cur ? sop_seq_w[sel] : seg_seq_w[sel] + 4'h1;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (req_valid && req_ready_q) state_d = ST_GAP;
            ST_GAP: if (gap_go) state_d = ready_sel ? ST_RECV : ST_DRAIN;
            ST_RECV:
                if (stat_go)
                    state_d = ST_STAT;
                else if (fail_ev || ok_ev)
                    state_d = ST_DRAIN;
            ST_STAT: state_d = ST_DRAIN;
            ST_DRAIN: if (reads_left_q == 2'h0) state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            req_ready_q <= 1'b0;
            req_q <= '0;
            sop_seen_q <= 1'b0;
            eop_seen_q <= 1'b0;
            status_req_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            req_ready_q <= state_d == ST_IDLE;
            status_req_q <= stat_go;
            if (req_valid && req_ready_q)
            begin
                req_q <= req_data;
                sop_seen_q <= 1'b0;
                eop_seen_q <= 1'b0;
            end
            else if (bus_cyc)
            begin
                sop_seen_q <= sop_cur;
                eop_seen_q <= eop_cur;
            end
        end
    end

    // ----------------------------------------
    // Completion and thread signalling
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            comp_q <= '0;
            reads_left_q <= 2'h0;
            comp_valid_q <= 1'b0;
            thr_valid_q <= 1'b0;
            thr_id_q <= 5'h0;
            sched_q <= 1'b0;
            coll_q <= 8'h00;
            gap_q <= 3'h0;
            last_sel_q <= 1'b0;
            last_valid_q <= 1'b0;
        end
        else
        begin
            thr_valid_q <= done_ev;
            sched_q <= done_ev && sig_sched_q;
            if (done_ev)
            begin
                // Scheduler also reads the entry, so hold for two reads
                reads_left_q <= sig_sched_q ? 2'h2 : 2'h1;
                comp_valid_q <= 1'b1;
                coll_q <= coll_q + 8'h01;
                gap_q <= `FPRTA_EOP_GAP;
                last_sel_q <= sel;
                last_valid_q <= 1'b1;
                thr_id_q <= cancel_ev ? req_q.thread_id : thr_pick;
                comp_q.msg <= cancel_ev ? `FPRTA_MSG_CANCEL : req_q.msg;
                comp_q.port_thd <= cancel_ev ? req_q.port :
                    fail_ev ? pt_fail : pt_ok;
                comp_q.sop_seq <= (!cancel_ev && sop_cur) ?
                    sop_seq_w[sel] : 4'h0;
                comp_q.fail <= fail_ev;
                comp_q.err <= 1'b0;
                comp_q.element_second <= req_q.element_second;
                comp_q.element_first <= req_q.element_first;
                comp_q.seq_sel <= sel;
                comp_q.eop <= !cancel_ev && eop_cur;
                comp_q.sop <= !cancel_ev && sop_cur;
                comp_q.seg_seq <= cancel_ev ? 4'h0 : seg_rep;
            end
            else
            begin
                if (comp_read && reads_left_q != 2'h0)
                begin
                    reads_left_q <= reads_left_q - 2'h1;
                    comp_valid_q <= reads_left_q != 2'h1;
                end
                if (gap_q != 3'h0)
                    gap_q <= gap_q - 3'h1;
            end
        end
    end

    // Hold register is shared by both fast ports
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            header_q <= 5'h0;
            body_q <= 5'h0;
            body_valid_q <= 1'b0;
        end
        else if ((ok_ev || fail_ev) && !(mode_q == `FPRTA_MODE_EXPL))
        begin
            if (sop_cur)
            begin
                header_q <= req_q.thread_id;
                body_valid_q <= 1'b0;
            end
            else if (m_hb && !body_valid_q)
            begin
                body_q <= req_q.thread_id;
                body_valid_q <= 1'b1;
            end
        end
    end

    for (genvar p = 0; p < 2; p++)
    begin : g_port
        fprta_port_ctx #(.WAIT_W(4)) u_ctx (
            .clk(clk),
            .reset_n(reset_n),
            .wait_len(p == 0 ? wait_a_q : wait_b_q),
            .done(done_ev && sel == 1'(p)),
            .adv((ok_ev || fail_ev) && sel == 1'(p)),
            .sop(sop_cur),
            .wait_busy(busy_w[p]),
            .sop_seq(sop_seq_w[p]),
            .seg_seq(seg_seq_w[p])
        );
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign req_ready = req_ready_q;
    assign status_req = status_req_q;
    assign comp_valid = comp_valid_q;
    assign comp_data = comp_q;
    assign thread_sig_valid = thr_valid_q;
    assign thread_sig_id = thr_id_q;
    assign sched_sig = sched_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence eop_with_stat;
        stat_go;
    endsequence
    sequence stat_then_done;
        status_req_q ##1 thread_sig_valid;
    endsequence

    cancel_fields_a: assert property (cancel_ev |=> comp_valid &&
        comp_q.msg == `FPRTA_MSG_CANCEL && !comp_q.fail && !comp_q.sop)
        else $error("cancel status fields wrong");
    fail_fields_a: assert property (fail_ev |=> comp_q.fail &&
        !comp_q.err && comp_q.seq_sel == $past(sel))
        else $error("failure status fields wrong");
    single_header_a: assert property ((ok_ev && m_one && !sop_cur)
        |=> thread_sig_id == $past(header_q))
        else $error("single mode did not signal header thread");
    explicit_thread_a: assert property ((ok_ev || fail_ev) &&
        mode_q == `FPRTA_MODE_EXPL |=> thread_sig_id == $past(req_q.thread_id))
        else $error("explicit mode thread substituted");
    gap_hold_a: assert property ((state_q == ST_GAP && b2b)
        |=> state_q == ST_GAP)
        else $error("back-to-back gap not kept");
    double_read_a: assert property ((done_ev && sig_sched_q)
        |=> comp_valid ##1 (comp_valid || $past(comp_read)))
        else $error("completion removed before two reads");
    status_first_a: assert property (eop_with_stat |=> stat_then_done)
        else $error("status not requested before completion");
    sched_sig_a: assert property (done_ev |=> sched_sig ==
        $past(sig_sched_q) && thread_sig_valid)
        else $error("scheduler signal mismatch");

endmodule // fprta_top

// >>> bench/fprta_rx_dev.sv
module fprta_rx_dev
    import fprta_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Bench control
    input wire logic go,
    input wire logic [1:0] rdy,
    input wire fprta_bus_t beat,
    // Device pins
    output logic ready_in_port_a,
    output logic ready_in_port_b,
    output fprta_bus_t rx_bus
);
    timeunit 1ns;
    timeprecision 1ns;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ready_in_port_a <= 1'b0;
            ready_in_port_b <= 1'b0;
            rx_bus <= '0;
        end
        else
        begin
            {ready_in_port_b, ready_in_port_a} <= rdy;
            // Released bus carries junk, never a stale beat
            rx_bus <= go ? beat : {1'b0, ~rx_bus[3:0]};
        end
    end
endmodule // fprta_rx_dev

// >>> bench/tb_fast_port_rx_thread_assign.sv
module tb_fast_port_rx_thread_assign
    import fprta_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, reset_n = 1'b0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic req_valid = 0, go = 0, comp_read = 0, eop_on = 0;
    logic [1:0] rdy = '0;
    fprta_req_t req = '0;
    fprta_bus_t beat = '0;
    wire awready, wready, bvalid, arready, rvalid, req_ready, ra, rb;
    wire comp_valid, tsv, sched_sig, stat_w;
    wire [1:0] rresp, bresp;
    wire [31:0] rdata;
    wire [4:0] tsid;
    fprta_bus_t rx_bus;
    fprta_comp_t comp;
    int num_errors = 0, total_checks = 0, cyc = 0;
    int hdr = 0, bdy = 0, bv = 0, cnt = 0, nst = 0;
    int ss[2] = '{0, 0};

    fprta_top u_dut (.clk(clk), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .req_valid(req_valid), .req_data(req), .req_ready(req_ready),
        .ready_in_port_a(ra), .ready_in_port_b(rb), .rx_bus(rx_bus),
        .status_req(stat_w), .comp_valid(comp_valid), .comp_data(comp),
        .comp_read(comp_read), .thread_sig_valid(tsv),
        .thread_sig_id(tsid), .sched_sig(sched_sig));

    fprta_rx_dev u_dev (.clk(clk), .reset_n(reset_n), .go(go), .rdy(rdy),
        .beat(beat), .ready_in_port_a(ra), .ready_in_port_b(rb),
        .rx_bus(rx_bus));

    initial
    begin
        forever #50 clk = ~clk;
    end

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic chk(input logic [35:0] g, input logic [35:0] e);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected at %0t: got %0h exp %0h", $time, g, e);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        // Response ready stays high between writes
        chk(bresp, 2'h0);
    endtask

    task automatic axr(input logic [7:0] a, input logic [33:0] e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        chk({rresp, rdata}, e);
    endtask

    // One request through the model; ok low means port not ready
    task automatic rx(input int md, input logic sp, fl, ok, sch);
        fprta_req_t q;
        logic [4:0] et;
        logic [4:0] ept;
        q = fprta_req_t'(21'($urandom));
        req <= q;
        rdy <= q.fast_sel ? {ok, !ok} : {!ok, ok};
        beat <= {1'b1, sp, eop_on, fl, 1'b1};
        req_valid <= 1'b1;
        do
            @(posedge clk);
        while (!req_ready);
        req_valid <= 1'b0;
        if (ok)
        begin
            repeat ($urandom_range(2)) @(posedge clk);
            go <= 1'b1;
        end
        do
            @(posedge clk);
        while (!tsv);
        go <= 1'b0;
        et = q.thread_id;
        ept = q.port;
        if (ok && md == 2 && sp)
            hdr = q.thread_id;
        else if (ok && md == 2)
            {et, ept} = {5'(hdr), q.thread_id};
        else if (ok && md == 1 && sp)
            {hdr, bv} = {32'(q.thread_id), 32'd0};
        else if (ok && md == 1 && bv == 0)
            {bdy, bv} = {32'(q.thread_id), 32'd1};
        else if (ok && md == 1)
            {et, ept} = {5'(bdy), fl ? q.port : q.thread_id};
        chk(tsid, et);
        chk(comp.port_thd, ept);
        chk({sched_sig, comp.fail, comp.err, comp.eop},
            {sch, ok & fl, 1'b0, ok & eop_on});
        chk({comp.element_first, comp.element_second},
            {q.element_first, q.element_second});
        if (!ok)
            chk({comp.msg, comp.sop}, {2'h3, 1'b0});
        if (ok && fl)
            chk({comp.msg, comp.seq_sel, comp.sop},
                {q.msg, q.fast_sel, sp});
        if (ok && sp)
            chk({comp.sop_seq, comp.seg_seq},
                {2{4'(ss[q.fast_sel])}});
        ss[q.fast_sel] += int'(ok && sp);
        cnt += int'(!ok || fl);
        comp_read <= 1'b1;
        @(posedge clk);
        comp_read <= 1'b0;
        @(posedge clk);
        chk(comp_valid, sch);
        if (sch)
        begin
            comp_read <= 1'b1;
            @(posedge clk);
            comp_read <= 1'b0;
            @(posedge clk);
            chk(comp_valid, 1'b0);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        nst += int'(stat_w === 1'b1);
        if (cyc == 8000)
        begin
            num_errors++;
            stop_test();
        end
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h9980));
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        axr(8'h04, 34'h66);
        axr(8'h00, 34'h0);
        axr(8'h10, {2'h2, 32'h0});
        $display("test reset done");
        axw(8'h04, 32'h0);
        rx(0, 1'b1, 1'b0, 1'b0, 1'b0);
        rx(0, 1'b1, 1'b1, 1'b1, 1'b0);
        axr(8'h0C, 34'({4'(ss[1]), 4'(ss[0]), 8'(cnt)}));
        $display("test cancel and fail done");
        for (int md = 0; md < 3; md++)
        begin
            axw(8'h00, 32'(md << 13) | 32'(md == 1) << 5);
            rx(md, 1'b1, 1'b0, 1'b1, md == 1);
            rx(md, 1'b0, 1'b0, 1'b1, md == 1);
            rx(md, 1'b0, 1'b1, 1'b1, md == 1);
            rx(md, 1'b0, 1'b0, 1'b0, md == 1);
            $display("test mode %0d done", md);
        end
        axw(8'h04, 32'h33);
        axw(8'h00, 32'h1);
        eop_on = 1'b1;
        rx(0, 1'b1, 1'b0, 1'b1, 1'b0);
        rx(0, 1'b0, 1'b1, 1'b1, 1'b0);
        chk(32'(nst), 32'd1);
        $display("test status done");
        stop_test();
    end
endmodule // tb_fast_port_rx_thread_assign
